// >>> verilog/eis_defs.svh
// eis_defs.svh: offsets, field positions, reset values of the sensitivity unit
// assumes: included by bare name by the design module eis_ctrl only, not by the package
`ifndef EIS_DEFS_SVH
`define EIS_DEFS_SVH

`define EIS_ADDR_W 8
`define EIS_OFS_PRIO0 8'h24
`define EIS_OFS_PRIO1 8'h25
`define EIS_OFS_PRIO2 8'h26
`define EIS_OFS_PRIO3 8'h27
`define EIS_OFS_CTRL 8'h28
`define EIS_OFS_STATUS 8'h29
`define EIS_OFS_MASK 8'h2A
`define EIS_OFS_PEND 8'h2B
`define EIS_PRIO_RST 8'hFF
`define EIS_PRIO3_RO 8'hF0
`define EIS_CTRL_RST 8'h00
`define EIS_CTRL_WMASK 8'hFC
`define EIS_MASK_RST 8'h00
`define EIS_PB_SENSE_HI 7
`define EIS_PB_SENSE_LO 6
`define EIS_PB_POL 5
`define EIS_PAF_SENSE_HI 4
`define EIS_PAF_SENSE_LO 3
`define EIS_PA_POL 2
`define EIS_NSRC 4
`define EIS_PRIO_LVL0 2'b10

`endif

// >>> verilog/eis_pkg.sv
// eis_pkg.sv: types shared by the sensitivity unit
// assumes: codes written here as literals, nothing taken from eis_defs.svh
package eis_pkg;
  // sensitivity field codes
  typedef enum logic [1:0] {
    EIS_SENSE_EDGE_LVL = 2'b00,
    EIS_SENSE_RISE = 2'b01,
    EIS_SENSE_FALL = 2'b10,
    EIS_SENSE_BOTH = 2'b11
  } eis_sense_type;
endpackage : eis_pkg

// >>> verilog/eis_pin_sync.sv
// eis_pin_sync.sv: three-stage pin synchroniser, change taken when stages 2 and 3 agree
// assumes: pin asynchronous to mclk_i
`timescale 1ns/1ps
module eis_pin_sync (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_nxt;

  // stage 1 read only by stage 2
  assign level_nxt = (s2_r == s3_r) ? s3_r : level_o;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_o <= 1'b1;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_o <= level_nxt;
    end
  end
endmodule : eis_pin_sync

// >>> verilog/eis_detect.sv
// eis_detect.sv: edge/level detector of one external source with pending flag
// assumes: level_i already synchronised; sense and polarity from the control register
`timescale 1ns/1ps
module eis_detect (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic level_i,
  input wire eis_pkg::eis_sense_type sense_i,
  input wire logic invert_i,
  input wire logic clear_i,
  output logic pend_o,
  output logic req_o
);
  import eis_pkg::*;
  logic prev_r;
  logic lvl;
  logic rise;
  logic fall;
  logic hit;
  logic pend_nxt;

  // polarity swaps what counts as rising and falling
  assign lvl = level_i ^ invert_i;
  assign rise = lvl & ~prev_r;
  assign fall = ~lvl & prev_r;
  assign hit = (sense_i == EIS_SENSE_EDGE_LVL) ? fall :
               (sense_i == EIS_SENSE_RISE) ? rise :
               (sense_i == EIS_SENSE_FALL) ? fall : (rise | fall);
  // edge wins over a clear in the same cycle
  assign pend_nxt = hit | (pend_o & ~clear_i);
  // level mode keeps requesting while active
  assign req_o = pend_o | ((sense_i == EIS_SENSE_EDGE_LVL) & ~lvl);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_r <= 1'b1;
      pend_o <= 1'b0;
    end else begin
      prev_r <= lvl;
      pend_o <= pend_nxt;
    end
  end
endmodule : eis_detect

// >>> verilog/eis_ctrl.sv
// eis_ctrl.sv: external interrupt sensitivity unit, priority registers, status and mask
// assumes: plain register port, read data one cycle after read strobe; cpu mask bits
// come from the core on mclk_i; pins are asynchronous
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "eis_defs.svh"
module eis_ctrl (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_mask_high_bit_i,
  input wire logic cpu_mask_low_bit_i,
  input wire logic ext_line_a3_e1_i,
  input wire logic ext_line_f_i,
  input wire logic ext_line_b_low_i,
  input wire logic ext_line_b4_i,
  output logic [3:0] ext_req_o,
  output logic irq_o
);
  import eis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] prio_r [0:3];
  logic [7:0] ctrl_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] status_nxt;
  logic [7:0] rdata_nxt;
  logic [3:0] pend;
  logic [3:0] req;
  logic [3:0] req_nxt;
  logic [3:0] lvl;
  logic [3:0] pins;
  logic [3:0] inv;
  logic [7:0] raw_rd;
  logic level3;
  logic wr_ctrl;
  logic ctrl_change;
  logic clr_pend;
  logic rd_status;
  logic [3:0] pend_prev_r;
  logic [3:0] pend_rise;
  eis_sense_type sense [0:3];

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign level3 = cpu_mask_high_bit_i & cpu_mask_low_bit_i;
  assign wr_ctrl = wr_i & (addr_i == `EIS_OFS_CTRL) & level3;
  // reserved bits forced low so they always read zero
  assign ctrl_nxt = wr_ctrl ? (wdata_i & `EIS_CTRL_WMASK) : ctrl_r;
  assign ctrl_change = wr_ctrl & ((wdata_i & `EIS_CTRL_WMASK) != ctrl_r);
  assign clr_pend = ctrl_change;
  assign rd_status = rd_i & (addr_i == `EIS_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // source mapping: 0 a3/e1, 1 port f, 2 port b low, 3 port b4
  assign pins = {ext_line_b4_i, ext_line_b_low_i, ext_line_f_i, ext_line_a3_e1_i};
  // shared fields, only 0 and 2 see polarity
  assign sense[0] = eis_sense_type'(ctrl_r[`EIS_PAF_SENSE_HI:`EIS_PAF_SENSE_LO]);
  assign sense[1] = eis_sense_type'(ctrl_r[`EIS_PAF_SENSE_HI:`EIS_PAF_SENSE_LO]);
  assign sense[2] = eis_sense_type'(ctrl_r[`EIS_PB_SENSE_HI:`EIS_PB_SENSE_LO]);
  assign sense[3] = eis_sense_type'(ctrl_r[`EIS_PB_SENSE_HI:`EIS_PB_SENSE_LO]);
  assign inv = {1'b0, ctrl_r[`EIS_PB_POL], 1'b0, ctrl_r[`EIS_PA_POL]};

  genvar gi;
  generate
    for (gi = 0; gi < `EIS_NSRC; gi = gi + 1) begin : g_src
      eis_pin_sync u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pins[gi]),
        .level_o(lvl[gi])
      );
      eis_detect u_det (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .level_i(lvl[gi]),
        .sense_i(sense[gi]),
        .invert_i(inv[gi]),
        .clear_i(clr_pend),
        .pend_o(pend[gi]),
        .req_o(req[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sticky status: a new pending request sets, read clears, set wins
  assign pend_rise = pend & ~pend_prev_r;
  assign status_nxt = {4'h0, pend_rise} | (rd_status ? 8'h00 : status_r);
  // no masking on a clearing write: a live level request must not blink
  assign req_nxt = req;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  assign raw_rd = (addr_i == `EIS_OFS_PRIO0) ? prio_r[0] :
                  (addr_i == `EIS_OFS_PRIO1) ? prio_r[1] :
                  (addr_i == `EIS_OFS_PRIO2) ? prio_r[2] :
                  (addr_i == `EIS_OFS_PRIO3) ? prio_r[3] :
                  (addr_i == `EIS_OFS_CTRL) ? ctrl_r :
                  (addr_i == `EIS_OFS_STATUS) ? status_r :
                  (addr_i == `EIS_OFS_MASK) ? mask_r :
                  (addr_i == `EIS_OFS_PEND) ? {4'h0, pend} : 8'h00;
  assign rdata_nxt = rd_i ? raw_rd : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // priority registers: each pair kept when level 0 code written
  genvar pr;
  genvar pb;
  generate
    for (pr = 0; pr < 4; pr = pr + 1) begin : g_prio
      logic [3:0] wr_pair;
      for (pb = 0; pb < 4; pb = pb + 1) begin : g_pair
        logic ro_pair;
        assign ro_pair = (pr == 3) && (pb >= 2);
        // pair meaning matches cpu mask bits; level 0 is not storable
        assign wr_pair[pb] = wr_i & (addr_i == (`EIS_OFS_PRIO0 + 8'(pr))) & ~ro_pair &
                             (wdata_i[2*pb+1 -: 2] != `EIS_PRIO_LVL0);
      end
      // one process per register so each word has a single driver
      always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          prio_r[pr] <= `EIS_PRIO_RST;
        end else begin
          for (int b = 0; b < 4; b++) begin
            if (wr_pair[b]) begin
              prio_r[pr][2*b+1 -: 2] <= wdata_i[2*b+1 -: 2];
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control, status, mask, outputs
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `EIS_CTRL_RST;
      status_r <= 8'h00;
      mask_r <= `EIS_MASK_RST;
      pend_prev_r <= 4'h0;
      rdata_o <= 8'h00;
      ext_req_o <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      if (wr_i && addr_i == `EIS_OFS_MASK) begin
        mask_r <= {4'h0, wdata_i[3:0]};
      end
      pend_prev_r <= pend;
      rdata_o <= rdata_nxt;
      ext_req_o <= req_nxt;
      irq_o <= |(status_nxt & mask_r);
    end
  end
endmodule : eis_ctrl

// >>> tb/eis_far.sv
// eis_far.sv: pin and cpu mask model in front of the unit
// assumes: bench commands change right after a rising edge
`timescale 1ns/1ps
module eis_far (
  input wire logic [3:0] pin_cmd_i,
  input wire logic lvl3_i,
  output logic [3:0] pin_o,
  output logic mask_hi_o,
  output logic mask_lo_o
);
  // pins always driven, so no pull level to model
  assign pin_o = pin_cmd_i;
  // only level 3 or level 2, never the level 0 code
  assign mask_hi_o = lvl3_i;
  assign mask_lo_o = lvl3_i;
endmodule : eis_far

// >>> tb/eis_ctrl_properties.sv
// eis_ctrl_properties.sv: port checker of the sensitivity unit
// assumes: bound to eis_ctrl, one clock domain
`timescale 1ns/1ps
module eis_ctrl_chk (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic cpu_mask_high_bit_i,
  input wire logic cpu_mask_low_bit_i,
  input wire logic ext_line_f_i,
  input wire logic ext_line_b4_i,
  input wire logic [3:0] ext_req_o,
  input wire logic irq_o
);
  logic [7:0] ctl_r;
  logic [3:0] msk_r;
  wire lvl3 = cpu_mask_high_bit_i & cpu_mask_low_bit_i;
  wire mapped = addr_i >= 8'h24 && addr_i <= 8'h2B;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // shadow of what the unit must hold
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_r <= 8'h00;
      msk_r <= 4'h0;
    end else if (wr_i && addr_i == 8'h28 && lvl3) begin
      ctl_r <= wdata_i & 8'hFC;
    end else if (wr_i && addr_i == 8'h2A) begin
      msk_r <= wdata_i[3:0];
    end
  end
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  ctrl_rsv_a: assert property (rd_i && addr_i == 8'h28 |=> rdata_o[1:0] == 2'b00)
    else $error("reserved control bits set");
  prio3_ro_a: assert property (rd_i && addr_i == 8'h27 |=> rdata_o[7:4] == 4'hF)
    else $error("priority 3 upper bits wrong");
  ctrl_lock_a: assert property (rd_i && addr_i == 8'h28 |=> rdata_o == $past(ctl_r))
    else $error("control value wrong");
  f_level_a: assert property ((ctl_r[4:3] == 2'b00 && !ext_line_f_i) [*8] |-> ext_req_o[1])
    else $error("port f low level not requesting");
  b4_level_a: assert property ((ctl_r[7:6] == 2'b00 && !ext_line_b4_i) [*8] |-> ext_req_o[3])
    else $error("port b4 low level not requesting");
  mask_irq_a: assert property (msk_r == 4'h0 && $past(msk_r) == 4'h0 |-> !irq_o)
    else $error("irq with all masked");
endmodule : eis_ctrl_chk
bind eis_ctrl eis_ctrl_chk u_chk (.*);

// >>> tb/tb_ext_irq_sensitivity_ctrl.sv
// tb_ext_irq_sensitivity_ctrl.sv: self-checking bench of the sensitivity unit
// assumes: eis_far drives pins and mask bits, checker bound
`timescale 1ns/1ps
module tb_ext_irq_sensitivity_ctrl;
  logic mclk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, lvl3 = 1, p;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, cv;
  logic [3:0] pin_cmd = 4'h0, pin;
  logic [1:0] c;
  logic [7:0] rdata_o;
  logic [3:0] ext_req_o;
  logic mh, ml, irq_o;
  int error_cnt = 0, comparisons = 0;
  // addr, wdata, level 3, expected read
  logic [24:0] rows [9] = '{
    {8'h28, 8'hFC, 1'b1, 8'hFC}, {8'h28, 8'h00, 1'b0, 8'hFC}, {8'h28, 8'h24, 1'b1, 8'h24},
    {8'h24, 8'hCF, 1'b1, 8'hCF}, {8'h24, 8'h64, 1'b1, 8'h44}, {8'h27, 8'h05, 1'b1, 8'hF5},
    {8'h27, 8'hFA, 1'b1, 8'hF5}, {8'h2A, 8'h05, 1'b1, 8'h05}, {8'h30, 8'hFF, 1'b1, 8'h00}};
  eis_far far (.pin_cmd_i(pin_cmd), .lvl3_i(lvl3), .pin_o(pin), .mask_hi_o(mh), .mask_lo_o(ml));
  eis_ctrl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_mask_high_bit_i(mh),
    .cpu_mask_low_bit_i(ml), .ext_line_a3_e1_i(pin[0]), .ext_line_f_i(pin[1]),
    .ext_line_b_low_i(pin[2]), .ext_line_b4_i(pin[3]), .ext_req_o(ext_req_o), .irq_o(irq_o));
  initial forever #2 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 0;
    #1 chk("rdata", e, rdata_o);
  endtask : rd
  // expected request of one source: phase 0 low, 1 after rise, 2 after fall
  function automatic logic hit(input logic [1:0] k, input logic q, input int ph);
    logic [1:0] e;
    logic rs, fs;
    e = (q && k != 2'b00 && k != 2'b11) ? ~k : k;
    rs = e[0] | (e == 2'b00 && q);
    fs = e[1] | (e == 2'b00 && !q);
    return ph == 0 ? (e == 2'b00 && !q) : (ph == 1 ? rs : rs | fs);
  endfunction : hit
  task automatic req_chk(input logic [3:0] pv, input int ph);
    @(posedge mclk_i);
    pin_cmd <= pv;
    repeat (8) @(posedge mclk_i);
    #1 chk("ext_req", {4'h0, hit(c, 1'b0, ph), hit(c, p, ph), hit(c, 1'b0, ph), hit(c, p, ph)},
      {4'h0, ext_req_o});
  endtask : req_chk
  task automatic irq_chk(input logic e);
    @(posedge mclk_i);
    #1 chk("irq", {7'h00, e}, {7'h00, irq_o});
  endtask : irq_chk
  task print_verdict;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1;
    for (int a = 8'h24; a <= 8'h28; a++) begin
      rd(a[7:0], a == 8'h28 ? 8'h00 : 8'hFF);
    end
    rd(8'h2A, 8'h00);
    foreach (rows[i]) begin
      @(posedge mclk_i);
      lvl3 <= rows[i][8];
      wr(rows[i][24:17], rows[i][16:9]);
      rd(rows[i][24:17], rows[i][7:0]);
    end
    @(posedge mclk_i);
    lvl3 <= 1;
    // every code with both polarities, all four sources at once
    // forced change flips a sense field, never a polarity bit: no pin edge
    for (int k = 0; k < 8; k++) begin
      c = k[2:1];
      p = k[0];
      cv = {c, p, c, p, 2'b00};
      wr(8'h28, cv ^ 8'h80);
      wr(8'h28, cv);
      req_chk(4'h0, 0);
      req_chk(4'hF, 1);
      req_chk(4'h0, 2);
    end
    irq_chk(1'b1);
    wr(8'h2A, 8'h00);
    irq_chk(1'b0);
    wr(8'h2A, 8'h0F);
    irq_chk(1'b1);
    rd(8'h29, 8'h0F);
    irq_chk(1'b0);
    rd(8'h29, 8'h00);
    // same value written: pending requests survive
    wr(8'h28, 8'hFC);
    rd(8'h2B, 8'h0F);
    // reset in mid-run
    @(posedge mclk_i);
    arst_n_i <= 0;
    @(posedge mclk_i);
    #1 chk("rst_req", 8'h00, {4'h0, ext_req_o});
    chk("rst_irq", 8'h00, {7'h00, irq_o});
    chk("rst_rdata", 8'h00, rdata_o);
    @(posedge mclk_i);
    arst_n_i <= 1;
    rd(8'h28, 8'h00);
    // let the post-reset falling edge land, then a changed sense field clears it
    repeat (8) @(posedge mclk_i);
    wr(8'h28, 8'h80);
    rd(8'h2B, 8'h00);
    print_verdict();
  end
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
endmodule : tb_ext_irq_sensitivity_ctrl
